// file: src/dtcm_consts.svh
`ifndef DTCM_CONSTS_SVH
`define DTCM_CONSTS_SVH

// channel count and channel roles
`define DTCM_NCH 4
`define DTCM_CH_IN 2'h0
`define DTCM_CH_OUT 2'h1
`define DTCM_CH_SUP 2'h2
`define DTCM_CH_TMP 2'h3

// register selects inside a channel page
`define DTCM_R_LO 3'h0
`define DTCM_R_HI 3'h1
`define DTCM_R_HYS 3'h2
`define DTCM_R_CFG 3'h3
`define DTCM_R_SPN 3'h4
`define DTCM_R_DLY 3'h5
`define DTCM_R_STAT 3'h6
`define DTCM_PAGE_CH 3'h0

// reset values
`define DTCM_LAMP_AMBER 2'h1
`define DTCM_HI_RST 16'hffff
`define DTCM_DEF_FMI_IN 5'h04
`define DTCM_DEF_FMI_OUT 5'h05
`define DTCM_DEF_FMI_SUP 5'h04
`define DTCM_DEF_FMI_TMP 5'h00

// failure mode identifier and occurrence count limits
`define DTCM_FMI_MAX 5'h15
`define DTCM_FMI_CE 5'h1f
`define DTCM_OC_MAX 7'h7f

// status word field positions
`define DTCM_ST_FLG 0
`define DTCM_ST_OC 16

// timing: clock in kHz, tick in ms, periodic report in ms
`define DTCM_CLK_KHZ 10000
`define DTCM_TICK_MS 1
`define DTCM_DM1_PERIOD_MS 1000

`endif

// file: src/dtcm_pkg.sv
package dtcm_pkg;
    typedef enum logic [2:0] {
        DTCM_OT_OFF = 3'h0,
        DTCM_OT_CUR = 3'h1,
        DTCM_OT_VOLT = 3'h2,
        DTCM_OT_PWM = 3'h3,
        DTCM_OT_HOT = 3'h4
    } dtcm_otype_t;

    typedef enum logic [1:0] {
        DTCM_S_IDLE = 2'b01,
        DTCM_S_SEND = 2'b10
    } dtcm_fsm_t;

    typedef struct packed {
        dtcm_otype_t otype;
        logic [4:0] fmi;
        logic [1:0] lamp;
        logic latch;
        logic gen;
    } dtcm_cfg_t;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] hys;
        logic [15:0] dly;
        logic [18:0] spn;
        dtcm_cfg_t cfg;
    } dtcm_chcfg_t;

    typedef struct packed {
        logic flo;
        logic fhi;
        logic hiside;
        logic qual;
        logic act;
        logic prev;
        logic dirty;
        logic [6:0] oc;
        logic [15:0] tmr;
    } dtcm_chst_t;

    typedef struct packed {
        logic [2:0] page;
        logic [1:0] ch;
        logic [2:0] sel;
    } dtcm_addr_t;

    typedef struct packed {
        dtcm_addr_t addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dtcm_bus_t;

    typedef struct packed {
        logic start;
        logic [7:0] lamp;
        logic [2:0] count;
        logic multi;
    } dtcm_head_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [31:0] dtc;
    } dtcm_dtc_t;

    typedef struct packed {
        logic wr;
        logic [1:0] idx;
        logic [6:0] oc;
    } dtcm_nv_t;

    typedef struct packed {
        dtcm_chcfg_t [3:0] cfg;
        dtcm_chst_t [3:0] st;
        dtcm_fsm_t fsm;
        logic pend;
        logic [13:0] ms_cnt;
        logic [9:0] sec_cnt;
        logic [3:0] snap;
        dtcm_head_t head;
        dtcm_dtc_t dtc;
        dtcm_nv_t nv;
        logic [31:0] rdata;
        logic [3:0] act;
    } dtcm_state_t;
endpackage

// file: src/dtcm_manager.sv
`include "dtcm_consts.svh"

//
// Function
// - current output: open circuit when |feedback - command| exceeds hysteresis setting
// - output monitoring only for proportional-current and hotshot types
// - each flag except the output's sets at threshold, clears only after value backs off by hysteresis (output: half of it)
// - per-fault enable decides if active fault yields a trouble code
// - periodic DM1 every second while any fault has messages enabled
// - more than one active code: DM1 marked as multipacket transport
// - occurrence count per linked fault kept in non-volatile storage
// - new fault counts down its delay; persists whole delay then active, count up
// - newly active code triggers an immediate extra DM1
// - condition gone: flag clears, code goes previously-active, leaves DM1
// - latch option keeps code active until a DM11 clear request
// - lamp byte from per-fault lamp select, amber by default
// - zero SPN: fault never sends a diagnostic message
// - SPN change resets that fault's occurrence count to zero
// - failure mode identifier reconfigurable, only 0 to 21 and 31 accepted
// - low-side identifier: high occurrence reports its paired high code
// - other identifiers: both occurrences report the same code
// - trouble code is four bytes: SPN, FMI, conversion bit zero, count
module dtcm_manager #(
    parameter logic [13:0] MS_CYCLES = 14'(`DTCM_TICK_MS * `DTCM_CLK_KHZ),
    parameter logic [9:0] DM1_PERIOD_MS = 10'(`DTCM_DM1_PERIOD_MS)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dtcm_pkg::dtcm_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [3:0][15:0] mon,
    input wire logic [15:0] out_cmd,
    input wire logic dm11_req,
    input wire dtcm_pkg::dtcm_nv_t nv_ld,
    output dtcm_pkg::dtcm_nv_t nv_wr,
    output dtcm_pkg::dtcm_head_t dm1_head,
    output dtcm_pkg::dtcm_dtc_t dm1_dtc,
    output logic [3:0] dtc_active
);
    import dtcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] def_fmi(input int ch);
        case (2'(ch))
            `DTCM_CH_IN: def_fmi = `DTCM_DEF_FMI_IN;
            `DTCM_CH_OUT: def_fmi = `DTCM_DEF_FMI_OUT;
            `DTCM_CH_SUP: def_fmi = `DTCM_DEF_FMI_SUP;
            default: def_fmi = `DTCM_DEF_FMI_TMP;
        endcase
    endfunction

    function automatic dtcm_state_t rst_val();
        dtcm_state_t r;
        r = '0;
        r.fsm = DTCM_S_IDLE;
        for (int i = 0; i < `DTCM_NCH; i++) begin
            r.cfg[i].hi = `DTCM_HI_RST;
            r.cfg[i].cfg.lamp = `DTCM_LAMP_AMBER;
            r.cfg[i].cfg.fmi = def_fmi(i);
            r.cfg[i].cfg.otype = DTCM_OT_CUR;
        end
        return r;
    endfunction

    // high occurrence of a two-sided fault picks the partner code
    function automatic logic [4:0] fmi_map(input logic [4:0] fmi, input logic hi);
        logic [4:0] m;
        m = fmi;
        if (hi) begin
            case (fmi)
                5'h01: m = 5'h00;
                5'h04: m = 5'h03;
                5'h05: m = 5'h06;
                5'h11: m = 5'h0f;
                5'h12: m = 5'h10;
                5'h15: m = 5'h14;
                default: m = fmi;
            endcase
        end
        return m;
    endfunction

    function automatic logic [31:0] dtc_word(input logic [18:0] spn, input logic [4:0] fmi, input logic [6:0] oc);
        return {1'b0, oc, spn[18:16], fmi, spn[15:8], spn[7:0]};
    endfunction

    function automatic logic [7:0] lamp_bits(input logic [1:0] sel);
        return 8'(8'h01 << {sel, 1'b0});
    endfunction

    function automatic logic fmi_ok(input logic [4:0] fmi);
        return (fmi <= `DTCM_FMI_MAX) || (fmi == `DTCM_FMI_CE);
    endfunction

    // high-side flag: once set, value plus hysteresis must come back to the limit
    function automatic logic flag_hi(input logic was, input logic [15:0] v, input logic [15:0] hi,
                                     input logic [15:0] hys);
        logic [16:0] back;
        logic f;
        back = {1'b0, v} + {1'b0, hys};
        if (was) begin
            f = back > {1'b0, hi};
        end else begin
            f = v > hi;
        end
        return f;
    endfunction

    // low-side flag: widened sum so a limit near full scale cannot wrap
    function automatic logic flag_lo(input logic was, input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hys);
        logic [16:0] clr;
        logic f;
        clr = {1'b0, lo} + {1'b0, hys};
        if (was) begin
            f = {1'b0, v} < clr;
        end else begin
            f = v < lo;
        end
        return f;
    endfunction

    // status word: count in the upper half, live flags in the low bits
    function automatic logic [31:0] stat_word(input dtcm_chst_t s);
        logic [31:0] w;
        w = '0;
        w[`DTCM_ST_OC +: 7] = s.oc;
        w[`DTCM_ST_FLG +: 6] = {s.hiside, s.prev, s.act, s.qual, s.fhi, s.flo};
        return w;
    endfunction

    localparam dtcm_state_t RST_S = rst_val();

    ////////////////////////////////////////////////////////////////////////////
    dtcm_state_t q;
    dtcm_state_t d;
    logic tick_ms;
    logic tick_s;
    logic any_gen;
    logic new_evt;
    logic [3:0] linked;
    logic [3:0] rep;
    logic [3:0] set_dirty;
    logic [15:0] v;
    logic [16:0] diff;
    logic found;
    logic [7:0] lamp;
    logic [2:0] cnt;
    logic [3:0] rest;
    logic chsel;

    always_comb begin
        d = q;
        d.nv.wr = 1'b0;
        d.head.start = 1'b0;
        d.dtc = '0;
        d.rdata = '0;
        tick_ms = (q.ms_cnt == MS_CYCLES - 14'h1);
        d.ms_cnt = tick_ms ? 14'h0 : q.ms_cnt + 14'h1;
        tick_s = tick_ms && (q.sec_cnt == DM1_PERIOD_MS - 10'h1);
        if (tick_ms) begin
            d.sec_cnt = tick_s ? 10'h0 : q.sec_cnt + 10'h1;
        end
        any_gen = 1'b0;
        new_evt = 1'b0;
        set_dirty = '0;
        linked = '0;
        rep = '0;
        lamp = '0;
        cnt = '0;
        v = '0;
        diff = '0;
        chsel = 1'b0;
        for (int i = 0; i < `DTCM_NCH; i++) begin
            v = mon[i];
            linked[i] = q.cfg[i].cfg.gen && (q.cfg[i].spn != '0);
            any_gen = any_gen | q.cfg[i].cfg.gen;
            case (2'(i))
                `DTCM_CH_OUT: begin
                    diff = (v >= out_cmd) ? {1'b0, v - out_cmd} : {1'b0, out_cmd - v};
                    d.st[i].fhi = 1'b0;
                    if (q.cfg[i].cfg.otype == DTCM_OT_CUR || q.cfg[i].cfg.otype == DTCM_OT_HOT) begin
                        // clears at half the set level so a noisy feedback does not chatter
                        if (!q.st[i].flo) begin
                            d.st[i].flo = diff > {1'b0, q.cfg[i].hys};
                        end else begin
                            d.st[i].flo = diff > {2'b0, q.cfg[i].hys[15:1]};
                        end
                    end else begin
                        d.st[i].flo = 1'b0;
                    end
                end
                `DTCM_CH_TMP: begin
                    d.st[i].flo = 1'b0;
                    d.st[i].fhi = flag_hi(q.st[i].fhi, v, q.cfg[i].hi, q.cfg[i].hys);
                end
                default: begin
                    d.st[i].flo = flag_lo(q.st[i].flo, v, q.cfg[i].lo, q.cfg[i].hys);
                    d.st[i].fhi = flag_hi(q.st[i].fhi, v, q.cfg[i].hi, q.cfg[i].hys);
                end
            endcase
            if (!q.st[i].act) begin
                if ((q.st[i].flo || q.st[i].fhi) && linked[i]) begin
                    if (!q.st[i].qual) begin
                        d.st[i].qual = 1'b1;
                        d.st[i].tmr = q.cfg[i].dly;
                    end else if (q.st[i].tmr == '0) begin
                        d.st[i].qual = 1'b0;
                        d.st[i].act = 1'b1;
                        d.st[i].prev = 1'b0;
                        d.st[i].hiside = q.st[i].fhi;
                        if (q.st[i].oc != `DTCM_OC_MAX) begin
                            d.st[i].oc = q.st[i].oc + 7'h1;
                        end
                        set_dirty[i] = 1'b1;
                        new_evt = 1'b1;
                    end else if (tick_ms) begin
                        d.st[i].tmr = q.st[i].tmr - 16'h1;
                    end
                end else begin
                    d.st[i].qual = 1'b0;
                end
            end else if (!q.st[i].flo && !q.st[i].fhi && !q.cfg[i].cfg.latch) begin
                d.st[i].act = 1'b0;
                d.st[i].prev = 1'b1;
            end else if (q.cfg[i].cfg.latch && dm11_req) begin
                d.st[i].act = 1'b0;
                d.st[i].prev = 1'b1;
            end
            chsel = (bus.addr.page == `DTCM_PAGE_CH) && (bus.addr.ch == 2'(i));
            if (bus.wr && chsel) begin
                case (bus.addr.sel)
                    `DTCM_R_LO: d.cfg[i].lo = bus.wdata[15:0];
                    `DTCM_R_HI: d.cfg[i].hi = bus.wdata[15:0];
                    `DTCM_R_HYS: d.cfg[i].hys = bus.wdata[15:0];
                    `DTCM_R_DLY: d.cfg[i].dly = bus.wdata[15:0];
                    `DTCM_R_CFG: begin
                        d.cfg[i].cfg = dtcm_cfg_t'(bus.wdata[$bits(dtcm_cfg_t)-1:0]);
                        if (!fmi_ok(d.cfg[i].cfg.fmi)) begin
                            d.cfg[i].cfg.fmi = q.cfg[i].cfg.fmi;
                        end
                    end
                    `DTCM_R_SPN: begin
                        d.cfg[i].spn = bus.wdata[18:0];
                        if (bus.wdata[18:0] != q.cfg[i].spn) begin
                            d.st[i].oc = '0;
                            set_dirty[i] = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (bus.rd && chsel) begin
                case (bus.addr.sel)
                    `DTCM_R_LO: d.rdata = {16'h0, q.cfg[i].lo};
                    `DTCM_R_HI: d.rdata = {16'h0, q.cfg[i].hi};
                    `DTCM_R_HYS: d.rdata = {16'h0, q.cfg[i].hys};
                    `DTCM_R_DLY: d.rdata = {16'h0, q.cfg[i].dly};
                    `DTCM_R_CFG: d.rdata = 32'(q.cfg[i].cfg);
                    `DTCM_R_SPN: d.rdata = {13'h0, q.cfg[i].spn};
                    `DTCM_R_STAT: d.rdata = stat_word(q.st[i]);
                    default: d.rdata = '0;
                endcase
            end
            // restore count from non-volatile storage after power-up
            if (nv_ld.wr && nv_ld.idx == 2'(i)) begin
                d.st[i].oc = nv_ld.oc;
            end
            rep[i] = q.st[i].act && linked[i];
            if (rep[i]) begin
                lamp = lamp | lamp_bits(q.cfg[i].cfg.lamp);
                cnt = cnt + 3'h1;
            end
            d.act[i] = d.st[i].act;
        end
        // one count write per cycle; a count that changes again is rewritten
        found = 1'b0;
        for (int i = 0; i < `DTCM_NCH; i++) begin
            if (q.st[i].dirty && !found) begin
                found = 1'b1;
                d.nv = '{wr: 1'b1, idx: 2'(i), oc: d.st[i].oc};
                d.st[i].dirty = 1'b0;
            end
            if (set_dirty[i]) begin
                d.st[i].dirty = 1'b1;
            end
        end
        // channel list frozen at the head so a change mid-send cannot tear it
        rest = q.snap;
        found = 1'b0;
        case (q.fsm)
            DTCM_S_IDLE: begin
                if (q.pend) begin
                    d.pend = 1'b0;
                    d.snap = rep;
                    d.head = '{start: 1'b1, lamp: lamp, count: cnt, multi: cnt > 3'h1};
                    d.fsm = DTCM_S_SEND;
                end
            end
            DTCM_S_SEND: begin
                if (q.snap == '0) begin
                    d.dtc = '{valid: 1'b1, last: 1'b1, dtc: '0};
                    d.fsm = DTCM_S_IDLE;
                end else begin
                    for (int i = 0; i < `DTCM_NCH; i++) begin
                        if (q.snap[i] && !found) begin
                            found = 1'b1;
                            rest[i] = 1'b0;
                            d.dtc.valid = 1'b1;
                            d.dtc.dtc = dtc_word(q.cfg[i].spn, fmi_map(q.cfg[i].cfg.fmi, q.st[i].hiside),
                                                 q.st[i].oc);
                        end
                    end
                    d.snap = rest;
                    d.dtc.last = (rest == '0);
                    if (rest == '0) begin
                        d.fsm = DTCM_S_IDLE;
                    end
                end
            end
            default: d.fsm = DTCM_S_IDLE;
        endcase
        // a request raised while a report starts is kept for the next one
        if (new_evt || (tick_s && any_gen)) begin
            d.pend = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_S;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign nv_wr = q.nv;
    assign dm1_head = q.head;
    assign dm1_dtc = q.dtc;
    assign dtc_active = q.act;
endmodule // dtcm_manager

// file: verification/dtcm_manager_sva.sv
module dtcm_manager_sva #(
    parameter logic [13:0] MS_CYCLES = 14'h4,
    parameter logic [9:0] DM1_PERIOD_MS = 10'h3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dtcm_pkg::dtcm_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic [3:0][15:0] mon,
    input wire logic [15:0] out_cmd,
    input wire logic dm11_req,
    input wire dtcm_pkg::dtcm_nv_t nv_ld,
    input wire dtcm_pkg::dtcm_nv_t nv_wr,
    input wire dtcm_pkg::dtcm_head_t dm1_head,
    input wire dtcm_pkg::dtcm_dtc_t dm1_dtc,
    input wire logic [3:0] dtc_active
);
    timeunit 1ns;
    timeprecision 1ns;
    import dtcm_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("read data outside slot");
    a_unmapped_zero: assert property (bus.rd && (bus.addr.page != 3'h0 || bus.addr.sel == 3'h7)
        |=> rdata == 32'h0) else $error("unmapped read not zero");
    a_multi_count: assert property (dm1_head.start |-> dm1_head.multi == (dm1_head.count > 3'h1))
        else $error("multipacket flag wrong");
    a_head_then_code: assert property (dm1_head.start |=> dm1_dtc.valid) else $error("no code after head");
    a_cm_zero: assert property (dm1_dtc.valid |-> !dm1_dtc.dtc[31]) else $error("conversion bit set");
    a_last_ends: assert property (dm1_dtc.valid && dm1_dtc.last |=> !dm1_dtc.valid) else $error("code after last");
    a_no_fault_dm1: assert property (dm1_head.start && dm1_head.count == 3'h0 |-> dm1_head.lamp == 8'h0
        ##1 (dm1_dtc.valid && dm1_dtc.last && dm1_dtc.dtc == 32'h0)) else $error("bad empty report");
    a_new_code_dm1: assert property ((dtc_active & ~$past(dtc_active)) != 4'h0 |-> ##[1:10] dm1_head.start)
        else $error("no report after activation");
    a_new_code_nv: assert property ((dtc_active & ~$past(dtc_active)) != 4'h0 |-> ##[0:6] nv_wr.wr)
        else $error("no store after activation");
    c_multi: cover property (dm1_head.start && dm1_head.multi);
    c_empty: cover property (dm1_head.start && dm1_head.count == 3'h0);
    c_clear: cover property (dm11_req);
endmodule // dtcm_manager_sva

bind dtcm_manager dtcm_manager_sva #(.MS_CYCLES(MS_CYCLES), .DM1_PERIOD_MS(DM1_PERIOD_MS)) u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .mon(mon), .out_cmd(out_cmd),
    .dm11_req(dm11_req), .nv_ld(nv_ld), .nv_wr(nv_wr), .dm1_head(dm1_head), .dm1_dtc(dm1_dtc),
    .dtc_active(dtc_active));

// file: verification/dtcm_ecu_model.sv
module dtcm_ecu_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire dtcm_pkg::dtcm_head_t dm1_head,
    input wire dtcm_pkg::dtcm_dtc_t dm1_dtc,
    input wire dtcm_pkg::dtcm_nv_t nv_wr,
    input wire logic clr_go,
    input wire logic ld_go,
    output logic dm11_req,
    output dtcm_pkg::dtcm_nv_t nv_ld,
    output dtcm_pkg::dtcm_head_t head_q,
    output logic [31:0] dtc_q,
    output int dm1_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    import dtcm_pkg::*;
    logic [6:0] store[4] = '{default: 7'h0};
    logic [2:0] ld_i;
    // store ignores device reset, like real non-volatile memory
    always_ff @(posedge ref_clk) begin
        if (nv_wr.wr) store[nv_wr.idx] <= nv_wr.oc;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dm1_cnt <= 0;
            dm11_req <= 1'b0;
            nv_ld <= '0;
            ld_i <= 3'h0;
            head_q <= '0;
            dtc_q <= 32'h0;
        end else begin
            dm1_cnt <= dm1_cnt + int'(dm1_head.start);
            dm11_req <= clr_go;
            nv_ld <= '0;
            if (dm1_head.start) head_q <= dm1_head;
            if (dm1_dtc.valid) dtc_q <= dm1_dtc.dtc;
            if (ld_go) ld_i <= 3'h4;
            else if (ld_i != 3'h0) begin
                ld_i <= ld_i - 3'h1;
                nv_ld <= {1'b1, 2'(ld_i - 3'h1), store[2'(ld_i - 3'h1)]};
            end
        end
    end
endmodule // dtcm_ecu_model

// file: verification/tb_top.sv
`include "dtcm_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dtcm_pkg::*;
    // short tick and period keep the run small: period is 20 ticks of 4 cycles
    localparam logic [13:0] MSC = 14'h4;
    localparam logic [9:0] PER = 10'h14;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    dtcm_bus_t bus = '0;
    logic [3:0][15:0] mon = '0;
    logic [15:0] out_cmd = 16'h0;
    logic clr_go = 1'b0;
    logic ld_go = 1'b0;
    logic rd_p = 1'b0;
    logic [31:0] rdata, dtc_q;
    logic dm11_req;
    dtcm_nv_t nv_ld, nv_wr;
    dtcm_head_t dm1_head, head_q;
    dtcm_dtc_t dm1_dtc;
    logic [3:0] dtc_active;
    logic [15:0] rs = 16'd16740;
    logic [18:0] spn0, spn2;
    logic [4:0] dfmi[4] = '{`DTCM_DEF_FMI_IN, `DTCM_DEF_FMI_OUT, `DTCM_DEF_FMI_SUP, `DTCM_DEF_FMI_TMP};
    logic [63:0] q[$];
    int dm1_cnt, n, k;
    int bad_count = 0;
    int comparisons = 0;
    always #50 ref_clk = ~ref_clk;
    dtcm_manager #(.MS_CYCLES(MSC), .DM1_PERIOD_MS(PER)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .mon(mon), .out_cmd(out_cmd),
        .dm11_req(dm11_req), .nv_ld(nv_ld), .nv_wr(nv_wr), .dm1_head(dm1_head), .dm1_dtc(dm1_dtc),
        .dtc_active(dtc_active));
    dtcm_ecu_model u_ecu (.ref_clk(ref_clk), .rst_n(rst_n), .dm1_head(dm1_head), .dm1_dtc(dm1_dtc),
        .nv_wr(nv_wr), .clr_go(clr_go), .ld_go(ld_go), .dm11_req(dm11_req), .nv_ld(nv_ld),
        .head_q(head_q), .dtc_q(dtc_q), .dm1_cnt(dm1_cnt));
    ////////////////////////////////////////
    function automatic logic [15:0] xs();
        rs = rs ^ (rs << 7);
        rs = rs ^ (rs >> 9);
        rs = rs ^ (rs << 8);
        return rs;
    endfunction
    function automatic logic [7:0] ad(input int c, s);
        return 8'(c * 8 + s);
    endfunction
    function automatic logic [31:0] cw(input logic [2:0] ot, input logic [4:0] f, input logic [1:0] l,
        input logic la, g);
        return {20'h0, ot, f, l, la, g};
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, msk);
        comparisons++;
        if ((got & msk) !== (exp & msk)) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one access; the expected read word waits in the queue for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, m);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= w;
        bus.rd <= !w;
        if (!w) q.push_back({d, m});
        @(posedge ref_clk);
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
    endtask
    task automatic cfg(input int c, input logic [15:0] lo, hi, hys, dly, input logic [18:0] spn,
        input logic [31:0] w);
        acc(1, ad(c, 0), lo, 0);
        acc(1, ad(c, 1), hi, 0);
        acc(1, ad(c, 2), hys, 0);
        acc(1, ad(c, 4), spn, 0);
        acc(1, ad(c, 5), dly, 0);
        acc(1, ad(c, 3), w, 0);
    endtask
    task automatic setm(input int c, input logic [15:0] v);
        @(posedge ref_clk);
        mon[c] <= v;
    endtask
    task automatic idle(input int t);
        repeat (t) @(negedge ref_clk);
    endtask
    task automatic wait_act(input int c, input logic v);
        for (n = 0; n < 80 && dtc_active[c] !== v; n++) @(negedge ref_clk);
        chk(dtc_active[c], v, 1);
        if (n == 80) test_done();
    endtask
    always @(negedge ref_clk) begin
        if (rd_p) begin
            chk(rdata, q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
        end
        rd_p = bus.rd;
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            acc(0, ad(c, 1), 32'hffff, '1);
            acc(0, ad(c, 3), cw(3'h1, dfmi[c], 2'h1, 0, 0), '1);
        end
        acc(0, 8'h20, 0, '1);
        acc(0, ad(1, 7), 0, '1);
        chk(dm1_cnt, 0, '1);
        $display("test reset done");
        spn0 = 19'(xs());
        cfg(0, 100, 16'hffff, 10, 2, spn0, cw(1, 22, 1, 0, 1));
        acc(0, ad(0, 3), cw(1, 4, 1, 0, 1), '1);
        acc(1, ad(0, 3), cw(1, 31, 1, 0, 1), 0);
        acc(0, ad(0, 3), cw(1, 31, 1, 0, 1), '1);
        setm(0, 16'(xs() % 16'd100));
        wait_act(0, 1);
        acc(0, ad(0, 6), 32'h0001_0009, 32'h007f_0009);
        idle(12);
        chk(dtc_q, {1'b0, 7'h1, spn0[18:16], 5'h1f, spn0[15:0]}, '1);
        setm(0, 16'd105);
        idle(8);
        chk(dtc_active[0], 1, 1);
        setm(0, 16'd110);
        wait_act(0, 0);
        acc(0, ad(0, 6), 32'h0001_0010, 32'h007f_0019);
        acc(1, ad(0, 5), 5, 0);
        setm(0, 16'd0);
        idle(6);
        setm(0, 16'd200);
        idle(40);
        chk(dtc_active[0], 0, 1);
        acc(1, ad(0, 4), spn0 + 1, 0);
        acc(0, ad(0, 6), 0, 32'h007f_0000);
        $display("test input fault done");
        spn2 = 19'(xs());
        cfg(2, 0, 1000, 0, 0, spn2, cw(1, 4, 2, 1, 1));
        setm(2, 16'd1200);
        wait_act(2, 1);
        idle(12);
        chk(dtc_q, {1'b0, 7'h1, spn2[18:16], 5'h3, spn2[15:0]}, '1);
        chk(head_q.lamp, 8'h10, '1);
        setm(2, 16'd500);
        setm(0, 16'd0);
        wait_act(0, 1);
        idle(12);
        chk({head_q.lamp, head_q.count, head_q.multi}, {8'h14, 3'h2, 1'b1}, '1);
        chk(dtc_active[2], 1, 1);
        setm(0, 16'd200);
        wait_act(0, 0);
        @(posedge ref_clk);
        clr_go <= 1'b1;
        @(posedge ref_clk);
        clr_go <= 1'b0;
        wait_act(2, 0);
        $display("test latch done");
        cfg(1, 0, 16'hffff, 10, 0, 19'(xs()), cw(2, 5, 1, 0, 1));
        @(posedge ref_clk);
        out_cmd <= 16'd100;
        setm(1, 16'd500);
        idle(20);
        chk(dtc_active[1], 0, 1);
        acc(1, ad(1, 3), cw(1, 5, 1, 0, 1), 0);
        wait_act(1, 1);
        setm(1, 16'd105);
        wait_act(1, 0);
        cfg(3, 0, 10, 0, 0, 19'h5, cw(1, 0, 1, 0, 0));
        setm(3, 16'd100);
        idle(20);
        chk(dtc_active[3], 0, 1);
        acc(1, ad(3, 4), 0, 0);
        acc(1, ad(3, 3), cw(1, 0, 1, 0, 1), 0);
        idle(20);
        chk(dtc_active[3], 0, 1);
        setm(3, 16'd0);
        idle(10);
        k = dm1_cnt;
        idle(160);
        chk(dm1_cnt - k, 2, '1);
        $display("test output and periodic done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        ld_go <= 1'b1;
        @(posedge ref_clk);
        ld_go <= 1'b0;
        idle(8);
        acc(0, ad(2, 6), 32'h0001_0000, 32'h007f_0000);
        acc(0, ad(0, 6), 32'h0001_0000, 32'h007f_0000);
        idle(4);
        $display("test restore done");
        test_done();
    end
endmodule // tb_top
